// ### hdu_map.svh
// register map, field positions, reset values and baud counts of the
// half-duplex serial port; assumes a word-addressed wishbone slave.
`ifndef HDU_MAP_SVH
`define HDU_MAP_SVH
// register indices; the byte address is four times the index
`define HDU_IDX_DATA 10'h0D6
`define HDU_IDX_CTRL 10'h0D7
// control register fields
`define HDU_CR_RECEIVE_READY_FLAG 7
`define HDU_CR_TRANSMITTER_EMPTY_FLAG 6
`define HDU_CR_RECEIVE_IRQ_ENABLE 5
`define HDU_CR_TRANSMIT_IRQ_ENABLE 4
`define HDU_CR_BAUD_HI 3
`define HDU_CR_BAUD_LO 1
`define HDU_CR_NINTH 0
`define HDU_RST_BAUD 3'h0
`define HDU_RST_BYTE 8'h00
// core clock divisors per baud code, one bit time each
`define HDU_DIV_0 14'h1A00
`define HDU_DIV_1 14'h0D00
`define HDU_DIV_2 14'h0680
`define HDU_DIV_3 14'h0340
`define HDU_DIV_4 14'h01A0
`define HDU_DIV_5 14'h0100
`define HDU_DIV_6 14'h00D0
`define HDU_OVERSAMPLE 14'h0008
// bit timing in bit-clock ticks
`define HDU_PHASE_LAST 3'h7
`define HDU_SMP_FIRST 3'h3
`define HDU_SMP_LAST 3'h5
`define HDU_TX_LAST_BIT 4'hA
`define HDU_RX_LAST_BIT 4'h8
`define HDU_FRAME_IDLE 11'h7FF
`endif

// ### hdu_pkg.sv
// types and the baud decode of the half-duplex serial port;
// assumes hdu_map.svh supplies the constants.
`include "hdu_map.svh"
`default_nettype none
package hdu_pkg;
  typedef enum logic [1:0] {
    HDU_RX_IDLE = 2'b00,
    HDU_RX_START = 2'b01,
    HDU_RX_DATA = 2'b10,
    HDU_RX_STOP = 2'b11
  } hdu_rx_state_t;

  // cycles per bit-clock tick for a baud code; zero means no tick
  function automatic logic [10:0] hdu_tick_count(input logic [2:0] code);
    logic [13:0] div;
    div = 14'h0000;
    case (code)
      3'h0: div = `HDU_DIV_0;
      3'h1: div = `HDU_DIV_1;
      3'h2: div = `HDU_DIV_2;
      3'h3: div = `HDU_DIV_3;
      3'h4: div = `HDU_DIV_4;
      3'h5: div = `HDU_DIV_5;
      3'h6: div = `HDU_DIV_6;
      default: div = 14'h0000;
    endcase
    return 11'(div / `HDU_OVERSAMPLE);
  endfunction
endpackage
`default_nettype wire

// ### hdu_if.sv
// link between the register core and the two shift engines;
// assumes one clock shared by all three.
`default_nettype none
interface hdu_if;
  logic tick;
  logic tx_start;
  logic [7:0] tx_byte;
  logic tx_ninth;
  logic tx_busy;
  logic tx_done;
  logic tx_line;
  logic rx_level;
  logic rx_done;
  logic [7:0] rx_byte;
  logic rx_ninth;
  logic rx_active;
  modport core (output tick, tx_start, tx_byte, tx_ninth, rx_level,
    input tx_busy, tx_done, tx_line, rx_done, rx_byte, rx_ninth, rx_active);
  modport tx (input tick, tx_start, tx_byte, tx_ninth,
    output tx_busy, tx_done, tx_line);
  modport rx (input tick, rx_level, tx_busy, tx_start,
    output rx_done, rx_byte, rx_ninth, rx_active);
endinterface
`default_nettype wire

// ### hdu_tx.sv
// transmit engine: sends an 11-bit frame, eight ticks per bit;
// assumes the tick is a one-cycle pulse at eight times the baud rate.
`include "hdu_map.svh"
`default_nettype none
module hdu_tx
  import hdu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  hdu_if.tx lnk
);
  logic busy, next_busy;
  logic done, next_done;
  logic [10:0] frame, next_frame;
  logic [3:0] bitn, next_bitn;
  logic [2:0] phase, next_phase;

  // frame shifter; ones shift in behind so the line idles high
  always_comb
  begin
    next_busy = busy;
    next_done = 1'b0;
    next_frame = frame;
    next_bitn = bitn;
    next_phase = phase;
    if (lnk.tx_start)
    begin
      next_frame = {1'b1, lnk.tx_ninth, lnk.tx_byte, 1'b0};
      next_busy = 1'b1;
      next_bitn = 4'h0;
      next_phase = 3'h0;
    end
    else if (busy && lnk.tick)
    begin
      next_phase = phase + 3'h1;
      if (phase == `HDU_PHASE_LAST)
      begin
        // start, data lsb first, ninth, stop
        next_frame = {1'b1, frame[10:1]};
        next_bitn = bitn + 4'h1;
        if (bitn == `HDU_TX_LAST_BIT)
        begin
          next_busy = 1'b0;
          next_done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      frame <= `HDU_FRAME_IDLE;
      bitn <= 4'h0;
      phase <= 3'h0;
    end
    else
    begin
      busy <= next_busy;
      done <= next_done;
      frame <= next_frame;
      bitn <= next_bitn;
      phase <= next_phase;
    end
  end

  assign lnk.tx_busy = busy;
  assign lnk.tx_done = done;
  assign lnk.tx_line = frame[0];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_start_bit_low: assert property (
    lnk.tx_start |=> !lnk.tx_line && busy)
    else $error("start bit not driven low");
  a_stop_line_high: assert property (done |-> lnk.tx_line && !busy)
    else $error("line not high at end of frame");
endmodule // hdu_tx
`default_nettype wire

// ### hdu_rx.sv
// receive engine: falling-edge start, three votes per bit, nine bits;
// assumes rx_level is already synchronised to i_clk.
`include "hdu_map.svh"
`default_nettype none
module hdu_rx
  import hdu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  hdu_if.rx lnk
);
  hdu_rx_state_t state, next_state;
  logic [2:0] phase, next_phase;
  logic [3:0] bitn, next_bitn;
  logic [1:0] ones, next_ones;
  logic [8:0] shift, next_shift;
  logic prev, done, next_done;
  logic [7:0] byte_q, next_byte;
  logic ninth, next_ninth;
  logic bit_val;

  // two of three votes decide the bit
  assign bit_val = ones[1];

  // receive sequencer
  always_comb
  begin
    next_state = state;
    next_phase = phase;
    next_bitn = bitn;
    next_ones = ones;
    next_shift = shift;
    next_done = 1'b0;
    next_byte = byte_q;
    next_ninth = ninth;
    if (lnk.tick && state != HDU_RX_IDLE)
      next_phase = phase + 3'h1;
    case (state)
      HDU_RX_IDLE:
        if (prev && !lnk.rx_level)
        begin
          next_state = HDU_RX_START;
          next_phase = 3'h0;
        end
      HDU_RX_START:
        if (lnk.tick && phase == `HDU_PHASE_LAST)
        begin
          next_state = HDU_RX_DATA;
          next_bitn = 4'h0;
          next_ones = 2'h0;
        end
      HDU_RX_DATA:
        if (lnk.tick)
        begin
          // samples at ticks three to five
          if (phase >= `HDU_SMP_FIRST && phase <= `HDU_SMP_LAST &&
              lnk.rx_level)
            next_ones = ones + 2'h1;
          if (phase == `HDU_PHASE_LAST)
          begin
            next_shift = {bit_val, shift[8:1]};
            next_ones = 2'h0;
            next_bitn = bitn + 4'h1;
            if (bitn == `HDU_RX_LAST_BIT)
              next_state = HDU_RX_STOP;
          end
        end
      HDU_RX_STOP:
        if (lnk.tick && phase == `HDU_PHASE_LAST)
        begin
          // stop time over, hand to buffer
          next_state = HDU_RX_IDLE;
          next_done = 1'b1;
          next_byte = shift[7:0];
          next_ninth = shift[8];
        end
      default: next_state = HDU_RX_IDLE;
    endcase
    if (lnk.tx_start || lnk.tx_busy)
    begin
      next_state = HDU_RX_IDLE;
      next_done = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state <= HDU_RX_IDLE;
      phase <= 3'h0;
      bitn <= 4'h0;
      ones <= 2'h0;
      shift <= 9'h000;
      prev <= 1'b1;
      done <= 1'b0;
      byte_q <= `HDU_RST_BYTE;
      ninth <= 1'b0;
    end
    else
    begin
      state <= next_state;
      phase <= next_phase;
      bitn <= next_bitn;
      ones <= next_ones;
      shift <= next_shift;
      prev <= lnk.rx_level;
      done <= next_done;
      byte_q <= next_byte;
      ninth <= next_ninth;
    end
  end

  assign lnk.rx_done = done;
  assign lnk.rx_byte = byte_q;
  assign lnk.rx_ninth = ninth;
  assign lnk.rx_active = (state != HDU_RX_IDLE);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_rx_abort_tx: assert property (
    lnk.tx_start |=> state == HDU_RX_IDLE)
    else $error("reception survived a transmit start");
  a_edge_starts: assert property (
    state == HDU_RX_IDLE && prev && !lnk.rx_level && !lnk.tx_start &&
    !lnk.tx_busy |=> state == HDU_RX_START)
    else $error("falling edge did not start reception");
endmodule // hdu_rx
`default_nettype wire

// ### hdu_uart_top.sv
// half-duplex serial port with data and control registers on wishbone;
// assumes a classic wishbone master and an asynchronous receive pin.
//
// Chosen here: the Wishbone interface to the registers.
`include "hdu_map.svh"
`default_nettype none

module hdu_uart_top
  import hdu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [11:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_serial_output_active,
  output logic o_rx_irq,
  output logic o_tx_irq
);
  hdu_if lnk ();

  logic ack, next_ack;
  logic [7:0] rdat, next_rdat;
  logic receive_ready_flag, next_receive_ready_flag;
  logic transmitter_empty_flag, next_transmitter_empty_flag;
  logic receive_irq_enable, next_receive_irq_enable;
  logic transmit_irq_enable, next_transmit_irq_enable;
  logic [2:0] baud_select, next_baud;
  logic ninth_bit, next_ninth;
  logic [7:0] tx_byte, next_tx_byte;
  logic [10:0] tick_cnt, next_tick_cnt;
  logic tick, next_tick;
  logic sync1, sync2, sync3;
  logic rx_level, next_rx_level;
  logic req, hit_data, hit_ctrl, wr_data, wr_ctrl, rd_data;
  logic [10:0] tick_len;

  // a fresh request is taken once; the registered ack ends it
  assign req = i_wb_cyc && i_wb_stb && !ack;
  assign hit_data = (i_wb_adr[11:2] == `HDU_IDX_DATA);
  assign hit_ctrl = (i_wb_adr[11:2] == `HDU_IDX_CTRL);
  assign wr_data = req && i_wb_we && i_wb_sel[0] && hit_data;
  assign wr_ctrl = req && i_wb_we && i_wb_sel[0] && hit_ctrl;
  assign rd_data = req && !i_wb_we && hit_data;

  // divisor per baud code, no tick for the reserved code
  assign tick_len = hdu_tick_count(baud_select);

  // bit-clock divider: one tick per eighth of a bit
  always_comb
  begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 11'h001;
    if (wr_ctrl)
      // new rate restarts the divider at once
      next_tick_cnt = 11'h000;
    else if (tick_len == 11'h000)
      next_tick_cnt = 11'h000;
    else if (tick_cnt >= tick_len - 11'h001)
    begin
      next_tick_cnt = 11'h000;
      next_tick = 1'b1;
    end
  end

  // receive pin filter: a change counts once two late stages agree
  always_comb
  begin
    next_rx_level = rx_level;
    if (sync2 == sync3)
      next_rx_level = sync3;
  end

  // register writes, flag updates and read data
  always_comb
  begin
    next_ack = req;
    next_rdat = rdat;
    next_receive_ready_flag = receive_ready_flag;
    next_transmitter_empty_flag = transmitter_empty_flag;
    next_receive_irq_enable = receive_irq_enable;
    next_transmit_irq_enable = transmit_irq_enable;
    next_baud = baud_select;
    next_ninth = ninth_bit;
    next_tx_byte = tx_byte;
    if (wr_data)
    begin
      next_tx_byte = i_wb_dat[7:0];
      // data write empties the transmitter flag
      next_transmitter_empty_flag = 1'b0;
    end
    if (wr_ctrl)
    begin
      next_receive_ready_flag = i_wb_dat[`HDU_CR_RECEIVE_READY_FLAG];
      next_transmitter_empty_flag = i_wb_dat[`HDU_CR_TRANSMITTER_EMPTY_FLAG];
      // enable bits; they touch no flag
      next_receive_irq_enable = i_wb_dat[`HDU_CR_RECEIVE_IRQ_ENABLE];
      next_transmit_irq_enable = i_wb_dat[`HDU_CR_TRANSMIT_IRQ_ENABLE];
      next_baud = i_wb_dat[`HDU_CR_BAUD_HI:`HDU_CR_BAUD_LO];
      // level for later transmitted ninth bits
      next_ninth = i_wb_dat[`HDU_CR_NINTH];
    end
    // hardware sets win over same-cycle software clears
    // character in buffer
    if (lnk.rx_done)
    begin
      next_receive_ready_flag = 1'b1;
      // received ninth bit replaces the written one
      next_ninth = lnk.rx_ninth;
    end
    if (lnk.tx_done)
      next_transmitter_empty_flag = 1'b1;
    if (req && !i_wb_we)
    begin
      next_rdat = 8'h00;
      if (hit_data)
        // reads see the receive buffer only
        next_rdat = lnk.rx_byte;
      else if (hit_ctrl)
        next_rdat = {receive_ready_flag, transmitter_empty_flag,
          receive_irq_enable, transmit_irq_enable, baud_select, ninth_bit};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ack <= 1'b0;
      rdat <= `HDU_RST_BYTE;
      receive_ready_flag <= 1'b0;
      transmitter_empty_flag <= 1'b0;
      receive_irq_enable <= 1'b0;
      transmit_irq_enable <= 1'b0;
      baud_select <= `HDU_RST_BAUD;
      ninth_bit <= 1'b0;
      tx_byte <= `HDU_RST_BYTE;
      tick_cnt <= 11'h000;
      tick <= 1'b0;
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
      rx_level <= 1'b1;
    end
    else
    begin
      ack <= next_ack;
      rdat <= next_rdat;
      receive_ready_flag <= next_receive_ready_flag;
      transmitter_empty_flag <= next_transmitter_empty_flag;
      receive_irq_enable <= next_receive_irq_enable;
      transmit_irq_enable <= next_transmit_irq_enable;
      baud_select <= next_baud;
      ninth_bit <= next_ninth;
      tx_byte <= next_tx_byte;
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
      sync1 <= i_rxd;
      sync2 <= sync1;
      sync3 <= sync2;
      rx_level <= next_rx_level;
    end
  end

  // start pulse rises with the byte register, one cycle after the data write
  logic start_q;
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      start_q <= 1'b0;
    else
      start_q <= wr_data;
  end

  assign lnk.tick = tick;
  assign lnk.tx_start = start_q;
  assign lnk.tx_byte = tx_byte;
  assign lnk.tx_ninth = ninth_bit;
  assign lnk.rx_level = rx_level;

  hdu_tx u_tx (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .lnk(lnk.tx)
  );

  hdu_rx u_rx (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .lnk(lnk.rx)
  );

  // outputs; the line shows the shifter's bit 0 at all times, idle or sending
  assign o_wb_ack = ack;
  assign o_wb_dat = {24'h000000, rdat};
  assign o_txd = lnk.tx_line;
  assign o_serial_output_active = lnk.tx_busy;
  // receive request from flag and enable
  assign o_rx_irq = receive_ready_flag && receive_irq_enable;
  assign o_tx_irq = transmitter_empty_flag && transmit_irq_enable;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_write_sends: assert property (wr_data |=> ##1 lnk.tx_busy)
    else $error("data write did not start a frame");
  a_write_empties: assert property (
    wr_data && !lnk.tx_done |=> !transmitter_empty_flag)
    else $error("data write left transmitter-empty set");
  a_read_buffer: assert property (
    rd_data |=> o_wb_ack && o_wb_dat[7:0] == $past(lnk.rx_byte))
    else $error("data read did not return receive buffer");
  a_receive_ready_flag_sets: assert property (lnk.rx_done |=> receive_ready_flag)
    else $error("receive-ready not set after character");
  a_receive_ready_flag_sw_set: assert property (
    wr_ctrl && i_wb_dat[7] |=> receive_ready_flag &&
    o_rx_irq == receive_irq_enable)
    else $error("software set of receive-ready lost");
  a_transmitter_empty_flag_sets: assert property (lnk.tx_done |=> transmitter_empty_flag)
    else $error("transmitter-empty not set after stop bit");
  a_transmitter_empty_flag_clear: assert property (
    wr_ctrl && !i_wb_dat[6] && !lnk.tx_done |=> !transmitter_empty_flag)
    else $error("written zero did not clear transmitter-empty");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  a_tick_spacing: assert property (
    tick && baud_select == 3'h6 && !wr_ctrl |=> !tick [*8])
    else $error("bit clock ticks too close");

  // reserved code freezes the bit clock
  a_reserved_still: assert property (
    baud_select == 3'h7 |-> !tick)
    else $error("bit clock ticked on the reserved code");

  // written byte reaches the shifter with the start pulse
  a_byte_loaded: assert property (
    wr_data |=> lnk.tx_start && lnk.tx_byte == $past(i_wb_dat[7:0]))
    else $error("written byte not handed to the shifter");

  // flags move only on writes or engine events
  a_flags_kept: assert property (
    !wr_ctrl && !wr_data && !lnk.rx_done && !lnk.tx_done |=>
    $stable(receive_ready_flag) && $stable(transmitter_empty_flag))
    else $error("flag changed without a cause");

  // baud code takes the written field at once
  a_baud_loads: assert property (
    wr_ctrl |=> baud_select ==
    $past(i_wb_dat[`HDU_CR_BAUD_HI:`HDU_CR_BAUD_LO]))
    else $error("baud code not loaded on write");

  // received ninth bit replaces the stored one
  a_ninth_loads: assert property (
    lnk.rx_done |=> ninth_bit == $past(lnk.rx_ninth))
    else $error("received ninth bit not stored");

  // line idles high outside a frame
  a_line_idle: assert property (
    !lnk.tx_busy |-> o_txd)
    else $error("transmit line low while idle");

  // receiver stays idle while a frame is sent
  a_rx_quiet_tx: assert property (
    lnk.tx_busy |-> !lnk.rx_active)
    else $error("receiver active during transmission");

  // port leaves reset idle and quiet
  a_reset_idle: assert property (
    $rose(i_rst_n) |-> !o_serial_output_active && !o_rx_irq &&
    !o_tx_irq && !o_wb_ack && o_txd)
    else $error("port not idle after reset");
endmodule // hdu_uart_top
`default_nettype wire

// ### hdu_station.sv
// remote serial station: decodes frames from the port's transmit line
// and sends frames into its receive pin; assumes the bench's clock.
`default_nettype none
module hdu_station (
  input wire logic i_clk,
  input wire logic i_line,
  input wire logic [15:0] i_bit_cyc,
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_byte;
  logic got_ninth;
  logic got_stop;
  int got_count;
  longint fall_ns;
  longint low_ns;

  // width of the latest low pulse; with all-ones data it is the start bit
  always @(negedge i_line) fall_ns = $time;
  always @(posedge i_line) low_ns = $time - fall_ns;

  // start, data lsb first, ninth, stop
  // mid-bit sampling tolerates a start bit cut short by tick phase
  initial
  begin
    o_line = 1'h1;
    got_count = 0;
    fall_ns = 0;
    low_ns = 0;
    forever
    begin
      @(negedge i_line);
      repeat (i_bit_cyc / 2) @(posedge i_clk);
      for (int k = 0; k < 9; k++)
      begin
        repeat (i_bit_cyc) @(posedge i_clk);
        if (k < 8)
          got_byte[k] = i_line;
        else
          got_ninth = i_line;
      end
      repeat (i_bit_cyc) @(posedge i_clk);
      got_stop = i_line;
      got_count++;
    end
  end

  // frame into the port; a glitch spoils one vote of bit 0
  task automatic send_frame(input logic [7:0] b, input logic n,
    input logic glitch);
    logic [10:0] f;
    f = {1'h1, n, b, 1'h0};
    @(posedge i_clk);
    for (int k = 0; k < 11; k++)
    begin
      o_line <= f[k];
      if (glitch && k == 1)
      begin
        repeat (110) @(posedge i_clk);
        o_line <= ~f[k];
        repeat (20) @(posedge i_clk);
        o_line <= f[k];
        repeat (i_bit_cyc - 130) @(posedge i_clk);
      end
      else
        repeat (i_bit_cyc) @(posedge i_clk);
    end
  endtask
endmodule // hdu_station
`default_nettype wire

// ### tb_half_duplex_uart_regs.sv
// self-checking bench of the half-duplex serial port: registers over
// classic wishbone, remote station on the pins; one 200 MHz clock.
`include "hdu_map.svh"
`default_nettype none
module tb_half_duplex_uart_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic rx;
    logic glitch;
    logic [7:0] din;
    logic ninth;
    logic [7:0] dexp;
    logic nexp;
  } hdu_row_t;
  localparam logic [11:0] DATA_ADR = {`HDU_IDX_DATA, 2'h0};
  localparam logic [11:0] CTRL_ADR = {`HDU_IDX_CTRL, 2'h0};
  logic clk, rst_n, cyc, stb, we, ack, txd, active, rx_irq, tx_irq, rxd;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [15:0] bit_cyc;
  int n_fail, check_count, cycles;
  int div_tab [4] = '{832, 416, 256, 208};
  hdu_row_t rows [6] = '{
    '{1'h0, 1'h0, 8'hA5, 1'h0, 8'hA5, 1'h0},
    '{1'h0, 1'h0, 8'h3C, 1'h1, 8'h3C, 1'h1},
    '{1'h1, 1'h0, 8'h96, 1'h1, 8'h96, 1'h1},
    '{1'h1, 1'h1, 8'h01, 1'h0, 8'h01, 1'h0},
    '{1'h0, 1'h0, 8'h80, 1'h0, 8'h80, 1'h0},
    '{1'h1, 1'h1, 8'h00, 1'h1, 8'h00, 1'h1}};

  hdu_uart_top i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_rxd(rxd),
    .o_txd(txd), .o_serial_output_active(active), .o_rx_irq(rx_irq),
    .o_tx_irq(tx_irq));
  hdu_station i_station (.i_clk(clk), .i_line(txd), .i_bit_cyc(bit_cyc),
    .o_line(rxd));

  always #2.5 clk = ~clk;

  task automatic stop_test();
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // run ceiling well above the expected 39k cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      n_fail++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [11:0] a,
    input logic [7:0] d, input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h000000, d};
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 50);
    r = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 50)
      n_fail++;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'h1, a, d, 4'h1, r);
  endtask

  // polls the control register until the given flag reads one
  task automatic wait_flag(input int b, output logic [31:0] r);
    int n;
    n = 0;
    do
    begin
      wb(1'h0, CTRL_ADR, 8'h00, 4'hF, r);
      n++;
    end while (r[b] !== 1'h1 && n < 5000);
  endtask

  initial
  begin
    int n0, w, k;
    {clk, rst_n, cyc, stb, we, adr, sel, wdat} = '0;
    n_fail = 0;
    check_count = 0;
    cycles = 0;
    bit_cyc = 16'h00D0;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    wb(1'h0, CTRL_ADR, 8'h00, 4'hF, q);
    chk(q, 32'h0);
    chk({txd, active, rx_irq, tx_irq}, 4'h8);
    // unmapped place and a write without its low byte lane are ignored
    wr(12'h360, 8'hFF);
    wb(1'h0, 12'h360, 8'h00, 4'hF, q);
    chk(q, 32'h0);
    wb(1'h1, CTRL_ADR, 8'hFF, 4'h2, q);
    wb(1'h0, CTRL_ADR, 8'h00, 4'hF, q);
    chk(q, 32'h0);
    foreach (rows[i])
    begin
      // ninth bit set before the data write; tx rows preset empty
      wr(CTRL_ADR, {2'h0, rows[i].rx, ~rows[i].rx, 3'h6, rows[i].ninth});
      if (!rows[i].rx)
      begin
        wr(CTRL_ADR, {2'h1, 2'h1, 3'h6, rows[i].ninth});
        n0 = i_station.got_count;
        // data register is only written here, never read back
        wr(DATA_ADR, rows[i].din);
        wb(1'h0, CTRL_ADR, 8'h00, 4'hF, q);
        chk(q[6], 1'h0);
        chk(active, 1'h1);
        k = 0;
        while (i_station.got_count == n0 && k < 4000)
        begin
          @(posedge clk);
          k++;
        end
        chk({i_station.got_stop, i_station.got_byte, i_station.got_ninth},
          {1'h1, rows[i].dexp, rows[i].nexp});
        wb(1'h0, CTRL_ADR, 8'h00, 4'hF, q);
        chk(q[6], 1'h0);
        wait_flag(6, q);
        chk(q[6], 1'h1);
        chk({active, tx_irq}, 2'h1);
      end
      else
      begin
        i_station.send_frame(rows[i].din, rows[i].ninth, rows[i].glitch);
        wait_flag(7, q);
        chk(q[7:0], {4'hA, 3'h6, rows[i].nexp});
        chk({rx_irq, tx_irq}, 2'h2);
        wb(1'h0, DATA_ADR, 8'h00, 4'hF, q);
        chk(q, {24'h0, rows[i].dexp});
      end
    end
    // software raise and clear of receive-ready, and its enable
    wr(CTRL_ADR, 8'hAC);
    chk(rx_irq, 1'h1);
    wr(CTRL_ADR, 8'h2C);
    chk(rx_irq, 1'h0);
    wr(CTRL_ADR, 8'h8C);
    chk(rx_irq, 1'h0);
    wr(CTRL_ADR, 8'hBC);
    wb(1'h0, CTRL_ADR, 8'h00, 4'hF, q);
    chk(q, 32'hBC);
    chk({rx_irq, tx_irq}, 2'h2);
    // transmitter-empty cleared by writing zero
    wr(DATA_ADR, 8'h55);
    wait_flag(6, q);
    wr(CTRL_ADR, 8'h1C);
    wb(1'h0, CTRL_ADR, 8'h00, 4'hF, q);
    chk({q, tx_irq}, {32'h1C, 1'h0});
    // a transmit start in mid-reception drops the incoming character
    fork
      i_station.send_frame(8'h5A, 1'h1, 1'h0);
      begin
        repeat (700) @(posedge clk);
        wr(DATA_ADR, 8'hF0);
      end
    join
    wait_flag(6, q);
    chk(q[7], 1'h0);
    chk({i_station.got_byte, i_station.got_ninth}, {8'hF0, 1'h0});
    wb(1'h0, DATA_ADR, 8'h00, 4'hF, q);
    chk(q, 32'h0);
    // baud codes three to six; start bit of an all-ones frame
    for (int c = 0; c < 4; c++)
    begin
      wr(CTRL_ADR, {4'h0, 3'(c + 3), 1'h1});
      bit_cyc = 16'(div_tab[c]);
      wr(DATA_ADR, 8'hFF);
      wait_flag(6, q);
      w = int'(i_station.low_ns / 5);
      chk((w >= div_tab[c] - div_tab[c] / 8 && w <= div_tab[c] + 1) ?
        div_tab[c] : w, div_tab[c]);
      chk({i_station.got_byte, i_station.got_ninth}, 9'h1FF);
    end
    // reserved baud code: no bit clock, the frame stays in its start bit
    wr(CTRL_ADR, 8'h0F);
    wr(DATA_ADR, 8'h00);
    repeat (300) @(posedge clk);
    chk({txd, active}, 2'h1);
    // reset in mid-frame abandons it and clears the port
    bit_cyc = 16'h00D0;
    wr(CTRL_ADR, 8'h3C);
    wr(DATA_ADR, 8'h00);
    repeat (500) @(posedge clk);
    rst_n <= 1'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    wb(1'h0, CTRL_ADR, 8'h00, 4'hF, q);
    chk({q, txd, active, rx_irq, tx_irq}, {32'h0, 4'h8});
    stop_test();
  end
endmodule // tb_half_duplex_uart_regs
`default_nettype wire
